/* nvp_pkg.sv */
package nvp_pkg;

    // frame layout
    localparam int CODE_W = 8;
    localparam int FRAME_W = 16;
    localparam logic [4:0] EDGES_CTRL = 5'h08;
    localparam logic [4:0] EDGES_FULL = 5'h10;
    localparam logic [4:0] EDGES_SAT = 5'h11;
    localparam int OP_HI_POS = 5;
    localparam int OP_LO_POS = 4;
    localparam logic [7:0] CTRL_RSVD_MASK = 8'hcf;
    localparam int TAPS = 256;

    // reset values
    localparam logic [7:0] MIDSCALE = 8'h80;

    // timing, ref_clk at 250 MHz
    localparam int REF_PERIOD_NS = 4;
    localparam int INIT_TIME_US = 10;
    localparam int INIT_CYC = INIT_TIME_US * 1000 / REF_PERIOD_NS;
    localparam int STORE_TIME_MS = 12;
    localparam int STORE_CYC = STORE_TIME_MS * 1000000 / REF_PERIOD_NS;
    localparam int SCLK_MAX_KHZ = 5000;
    localparam int SCLK_HALF_CYC =
        (1000000 / SCLK_MAX_KHZ / REF_PERIOD_NS + 1) / 2;
    localparam int CS_HIGH_NS = 200;
    localparam int CS_HIGH_CYC =
        (CS_HIGH_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
    localparam int TMR_W = 22;

    typedef enum logic [1:0] {
        OP_WR_WIPER,
        OP_WR_STORED,
        OP_COPY_W2S,
        OP_COPY_S2W
    } nvp_op_t;

    function automatic logic [7:0] nvp_ctrl_byte(input nvp_op_t op);
        logic [7:0] b;
        b = 8'h00;
        b[OP_HI_POS] = op[1];
        b[OP_LO_POS] = op[0];
        return b;
    endfunction

    function automatic nvp_op_t nvp_op_of(input logic [7:0] b);
        return nvp_op_t'({b[OP_HI_POS], b[OP_LO_POS]});
    endfunction

endpackage

/* nvp_link_if.sv */
`timescale 1ns/10ps
interface nvp_link_if;
    logic cs_b;
    logic sclk;
    logic din;
    modport host (output cs_b, output sclk, output din);
    modport dev (input cs_b, input sclk, input din);
endinterface

/* nvp_dev.sv */
// What this block does
// - receive-only port: select, clock, data in
// - shift one bit per rising clock while selected
// - write commands 00/01 need 16 edges
// - copy commands take 8 or 16 edges
// - select rising executes; then ignore clock
// - host keeps select low whole frame
// - msb first: zeros, op bits, zeros, code
// - op 00 loads wiper, stored untouched
// - code selects one of 256 taps linearly
// - op 01 loads stored, wiper untouched
// - op 10 copies wiper into stored
// - op 11 copies stored into wiper
// - power-up recalls stored within 10 us
// - stored holds midscale from factory, persists
// - idle standby when not recalling, receiving or storing
// - store busy up to 12 ms
// - host clock at most 5 MHz
`timescale 1ns/10ps
module nvp_dev
    import nvp_pkg::*;
#(
    parameter int STORE_CYCLES = STORE_CYC
) (
    // system clock and power-on reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // factory programming of the persistent position
    input wire logic factory_b,
    // serial link, clocked by the host
    nvp_link_if.dev link,
    // position state
    output logic [CODE_W-1:0] wiper_position,
    output logic [CODE_W-1:0] stored_position,
    output logic [TAPS-1:0] tap_sel,
    // status
    output logic ready,
    output logic busy,
    output logic standby,
    output logic frame_done,
    output logic frame_discard
);

    typedef enum {ST_INIT, ST_READY, ST_STORE} nvp_dev_state_t;

    // link clock domain
    logic new_frame_r;
    logic [4:0] edge_cnt_r;
    logic [FRAME_W-1:0] shift_r;

    // system clock domain
    nvp_dev_state_t state_r;
    logic [TMR_W-1:0] tmr_r;
    logic cs_q1_r;
    logic cs_q2_r;
    logic cs_q3_r;
    logic [CODE_W-1:0] wiper_r;
    logic [CODE_W-1:0] stored_r;
    logic [TAPS-1:0] tap_r;
    logic ready_r;
    logic busy_r;
    logic standby_r;
    logic done_r;
    logic discard_r;

    logic frame_end;
    logic exec_go;
    logic [7:0] ctrl;
    logic [CODE_W-1:0] data;
    nvp_op_t op;
    logic frame_ok;

    // select high arms the next frame without needing a clock edge,
    // since the link clock stands still between frames
    always_ff @(posedge link.sclk or posedge link.cs_b) begin
        if (link.cs_b) begin
            new_frame_r <= 1'b1;
        end else begin
            new_frame_r <= 1'b0;
        end
    end

    always_ff @(posedge link.sclk) begin
        if (!link.cs_b) begin
            shift_r <= {shift_r[FRAME_W-2:0], link.din};
        end
    end

    always_ff @(posedge link.sclk) begin
        if (!link.cs_b) begin
            if (new_frame_r) begin
                edge_cnt_r <= 5'h01;
            end else if (edge_cnt_r != EDGES_SAT) begin
                edge_cnt_r <= edge_cnt_r + 5'h01;
            end
        end
    end

    // select passes two flops; shift_r and edge_cnt_r are then frozen
    // because no clock edge is taken while select is high
    always_ff @(posedge ref_clk) begin
        cs_q1_r <= link.cs_b;
        cs_q2_r <= cs_q1_r;
        cs_q3_r <= cs_q2_r;
    end

    assign frame_end = cs_q2_r & ~cs_q3_r;

    always_comb begin
        ctrl = shift_r[FRAME_W-1:CODE_W];
        data = shift_r[CODE_W-1:0];
        if (edge_cnt_r == EDGES_CTRL) begin
            ctrl = shift_r[CODE_W-1:0];
        end
        op = nvp_op_of(ctrl);
        frame_ok = 1'b0;
        if (edge_cnt_r >= EDGES_FULL) begin
            frame_ok = 1'b1;
        end else if (edge_cnt_r == EDGES_CTRL) begin
            frame_ok = op inside {OP_COPY_W2S, OP_COPY_S2W};
        end
        if ((ctrl & CTRL_RSVD_MASK) != 8'h00) begin
            frame_ok = 1'b0;
        end
    end

    // frames landing during recall or a store are dropped
    assign exec_go = frame_end && state_r == ST_READY && frame_ok;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_r <= ST_INIT;
            tmr_r <= TMR_W'(INIT_CYC - 1);
        end else begin
            unique case (state_r)
                ST_INIT: begin
                    if (tmr_r == '0) begin
                        state_r <= ST_READY;
                    end else begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
                ST_READY: begin
                    if (exec_go && op inside {OP_WR_STORED, OP_COPY_W2S}) begin
                        state_r <= ST_STORE;
                        tmr_r <= TMR_W'(STORE_CYCLES - 1);
                    end
                end
                ST_STORE: begin
                    if (tmr_r == '0) begin
                        state_r <= ST_READY;
                    end else begin
                        tmr_r <= tmr_r - 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (state_r == ST_INIT) begin
            wiper_r <= stored_r;
        end else if (exec_go && op == OP_WR_WIPER) begin
            wiper_r <= data;
        end else if (exec_go && op == OP_COPY_S2W) begin
            wiper_r <= stored_r;
        end
    end

    // not cleared by rst_b: it models the persistent cell
    always_ff @(posedge ref_clk) begin
        if (!factory_b) begin
            stored_r <= MIDSCALE;
        end else if (exec_go && op == OP_WR_STORED) begin
            stored_r <= data;
        end else if (exec_go && op == OP_COPY_W2S) begin
            stored_r <= wiper_r;
        end
    end

    // one-hot tap: code 0 is the bottom end, all ones the top end
    always_ff @(posedge ref_clk) begin
        tap_r <= '0;
        tap_r[wiper_r] <= 1'b1;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ready_r <= 1'b0;
            busy_r <= 1'b1;
            standby_r <= 1'b0;
        end else begin
            ready_r <= state_r == ST_READY;
            busy_r <= state_r != ST_READY;
            standby_r <= state_r == ST_READY && cs_q2_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            done_r <= 1'b0;
            discard_r <= 1'b0;
        end else begin
            done_r <= exec_go;
            discard_r <= frame_end && !exec_go;
        end
    end

    assign wiper_position = wiper_r;
    assign stored_position = stored_r;
    assign tap_sel = tap_r;
    assign ready = ready_r;
    assign busy = busy_r;
    assign standby = standby_r;
    assign frame_done = done_r;
    assign frame_discard = discard_r;

endmodule

/* nvp_host.sv */
`timescale 1ns/10ps
module nvp_host
    import nvp_pkg::*;
#(
    parameter int STORE_CYCLES = STORE_CYC,
    parameter int HALF_CYCLES = SCLK_HALF_CYC
) (
    // system clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // command request
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_op,
    input wire logic [CODE_W-1:0] cmd_code,
    input wire logic cmd_short,
    output logic cmd_ready,
    // serial link, clock made here by division
    nvp_link_if.host link
);

    typedef enum {H_IDLE, H_LOW, H_HIGH, H_HOLD, H_GAP, H_BUSY}
        nvp_host_state_t;

    nvp_host_state_t state_r;
    logic [TMR_W-1:0] tmr_r;
    logic [4:0] edges_r;
    logic [FRAME_W-1:0] frame_r;
    logic store_r;
    logic cs_b_r;
    logic sclk_r;
    logic din_r;
    logic ready_r;
    logic tick;
    logic take;
    nvp_op_t op;
    logic [FRAME_W-1:0] frame_new;

    assign tick = tmr_r == '0;
    assign op = nvp_op_t'(cmd_op);
    assign take = state_r == H_IDLE && ready_r && cmd_valid;
    assign frame_new = {nvp_ctrl_byte(op), cmd_code};

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_r <= H_IDLE;
            tmr_r <= '0;
            edges_r <= '0;
            store_r <= 1'b0;
        end else begin
            if (!tick) begin
                tmr_r <= tmr_r - 1'b1;
            end
            unique case (state_r)
                H_IDLE: begin
                    if (take) begin
                        state_r <= H_LOW;
                        tmr_r <= TMR_W'(HALF_CYCLES - 1);
                        edges_r <= (cmd_short && cmd_op[1]) ?
                            EDGES_CTRL : EDGES_FULL;
                        store_r <= op inside {OP_WR_STORED, OP_COPY_W2S};
                    end
                end
                H_LOW: begin
                    if (tick) begin
                        state_r <= H_HIGH;
                        tmr_r <= TMR_W'(HALF_CYCLES - 1);
                        edges_r <= edges_r - 5'h01;
                    end
                end
                H_HIGH: begin
                    if (tick) begin
                        state_r <= (edges_r == '0) ? H_HOLD : H_LOW;
                        tmr_r <= TMR_W'(HALF_CYCLES - 1);
                    end
                end
                H_HOLD: begin
                    if (tick) begin
                        state_r <= H_GAP;
                        tmr_r <= TMR_W'(CS_HIGH_CYC - 1);
                    end
                end
                H_GAP: begin
                    if (tick) begin
                        state_r <= store_r ? H_BUSY : H_IDLE;
                        tmr_r <= TMR_W'(STORE_CYCLES - 1);
                    end
                end
                H_BUSY: begin
                    if (tick) begin
                        state_r <= H_IDLE;
                    end
                end
            endcase
        end
    end

    // data changes only on the falling clock or with select, so it is stable a full
    // half period before each rising edge
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            cs_b_r <= 1'b1;
            sclk_r <= 1'b0;
            din_r <= 1'b0;
            frame_r <= '0;
        end else begin
            unique case (state_r)
                H_IDLE: begin
                    if (take) begin
                        cs_b_r <= 1'b0;
                        frame_r <= frame_new;
                        din_r <= frame_new[FRAME_W-1];
                    end
                end
                H_LOW: begin
                    if (tick) begin
                        sclk_r <= 1'b1;
                    end
                end
                H_HIGH: begin
                    if (tick) begin
                        sclk_r <= 1'b0;
                        frame_r <= {frame_r[FRAME_W-2:0], 1'b0};
                        din_r <= frame_r[FRAME_W-2];
                    end
                end
                H_HOLD: begin
                    if (tick) begin
                        cs_b_r <= 1'b1;
                        din_r <= 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            ready_r <= 1'b0;
        end else if (take) begin
            ready_r <= 1'b0;
        end else begin
            ready_r <= state_r == H_IDLE;
        end
    end

    assign cmd_ready = ready_r;
    assign link.cs_b = cs_b_r;
    assign link.sclk = sclk_r;
    assign link.din = din_r;

endmodule

/* nvp_link_checker.sv */
`timescale 1ns/10ps
module nvp_link_checker
    import nvp_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // link wires
    input wire logic cs_b,
    input wire logic sclk,
    input wire logic din,
    // device outputs
    input wire logic [CODE_W-1:0] wiper_position,
    input wire logic [TAPS-1:0] tap_sel,
    input wire logic ready,
    input wire logic busy,
    input wire logic standby,
    input wire logic frame_done,
    input wire logic frame_discard
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence s_frame_end;
        $rose(cs_b);
    endsequence
    sequence s_answer;
        ##[2:6] (frame_done || frame_discard);
    endsequence

    a_frame_answer: assert property (s_frame_end |-> s_answer)
        else $error("no answer after frame end");
    a_pulse_single: assert property (frame_done |->
        !frame_discard ##1 !frame_done) else $error("bad done pulse");
    a_discard_single: assert property (
        frame_discard |=> !frame_discard) else $error("bad discard pulse");
    a_idle_clock_low: assert property (cs_b |-> !sclk)
        else $error("clock runs while deselected");
    a_rise_selected: assert property ($rose(sclk) |->
        !cs_b && !$past(cs_b)) else $error("edge without select");
    a_data_held: assert property (
        sclk && $past(sclk) |-> $stable(din))
        else $error("data moved while clock high");
    a_clock_high_min: assert property ($rose(sclk) |=> sclk)
        else $error("clock high too short");
    a_tap_onehot: assert property (ready |=>
        tap_sel == (TAPS'(1) << $past(wiper_position)))
        else $error("tap select wrong");
    a_busy_not_ready: assert property (busy |-> !ready)
        else $error("ready while busy");
    a_standby_idle: assert property (standby |-> ready && !busy)
        else $error("standby while working");
    a_standby_sel: assert property (!cs_b [*5] |-> !standby)
        else $error("standby during frame");
    a_wiper_cause: assert property ($changed(wiper_position) && !busy
        |-> ##[0:3] frame_done) else $error("wiper moved unasked");
endmodule

/* nv_pot_serial_command_port_bench.sv */
`timescale 1ns/10ps
module nv_pot_serial_command_port_bench;
    import nvp_pkg::*;
    localparam int STORE_SIM = 200;
    localparam int LIMIT = 40000;
    logic ref_clk, rst_b, factory_b, cmd_valid, cmd_short, cmd_ready;
    logic [1:0] cmd_op;
    logic [7:0] cmd_code, exp_w, exp_s, w2, s2;
    logic [7:0] wiper_position, stored_position;
    logic [TAPS-1:0] tap_sel;
    logic ready, busy, standby, frame_done, frame_discard, done2, disc2;
    int n_mismatch = 0;
    int n_tests = 0;
    int cyc = 0;
    int n_d2 = 0;
    int n_x2 = 0;
    nvp_link_if lk();
    nvp_link_if lk2();
    nvp_host #(.STORE_CYCLES(STORE_SIM), .HALF_CYCLES(4)) nvp_host_inst (
        .ref_clk(ref_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
        .cmd_op(cmd_op), .cmd_code(cmd_code), .cmd_short(cmd_short),
        .cmd_ready(cmd_ready), .link(lk.host));
    nvp_dev #(.STORE_CYCLES(STORE_SIM)) nvp_dev_inst (
        .ref_clk(ref_clk), .rst_b(rst_b), .factory_b(factory_b),
        .link(lk.dev), .wiper_position(wiper_position),
        .stored_position(stored_position), .tap_sel(tap_sel),
        .ready(ready), .busy(busy), .standby(standby),
        .frame_done(frame_done), .frame_discard(frame_discard));
    // second device faces a bench driver that breaks the framing on purpose
    nvp_dev #(.STORE_CYCLES(STORE_SIM)) nvp_dev_inst_b (
        .ref_clk(ref_clk), .rst_b(rst_b), .factory_b(factory_b),
        .link(lk2.dev), .wiper_position(w2), .stored_position(s2),
        .tap_sel(), .ready(), .busy(), .standby(),
        .frame_done(done2), .frame_discard(disc2));
    nvp_link_checker nvp_link_checker_inst (
        .ref_clk(ref_clk), .rst_b(rst_b), .cs_b(lk.cs_b), .sclk(lk.sclk),
        .din(lk.din), .wiper_position(wiper_position), .tap_sel(tap_sel),
        .ready(ready), .busy(busy), .standby(standby),
        .frame_done(frame_done), .frame_discard(frame_discard));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cyc++;
        if (done2 === 1'b1) n_d2++;
        if (disc2 === 1'b1) n_x2++;
        if (cyc == LIMIT) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic check(input logic [TAPS-1:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask

    function automatic logic [15:0] apply(input logic [1:0] op,
                                          input logic [7:0] c, w, s);
        case (op)
            2'b00: w = c;
            2'b01: s = c;
            2'b10: s = w;
            default: w = s;
        endcase
        return {w, s};
    endfunction

    task automatic send(input logic [1:0] op, input logic [7:0] code,
                        input logic short_f);
        int k;
        k = 0;
        while (cmd_ready !== 1'b1 && k < 2000) begin
            tick();
            k++;
        end
        @(posedge ref_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_code <= code;
        cmd_short <= short_f;
        @(posedge ref_clk);
        cmd_valid <= 1'b0;
        k = 0;
        while (frame_done !== 1'b1 && k < 400) begin
            tick();
            k++;
        end
        check(TAPS'(k < 400), TAPS'(1));
        {exp_w, exp_s} = apply(op, code, exp_w, exp_s);
        tick();
        check(TAPS'(wiper_position), TAPS'(exp_w));
        check(TAPS'(stored_position), TAPS'(exp_s));
        check(tap_sel, TAPS'(1) << exp_w);
        if (op == 2'b01 || op == 2'b10) begin
            check(TAPS'(busy), TAPS'(1));
            repeat (STORE_SIM + 8) tick();
            check(TAPS'(busy), TAPS'(0));
        end
    endtask

    // reset held for five edges, then the recall is waited out
    task automatic power_up();
        int k;
        k = 0;
        repeat (5) @(posedge ref_clk);
        rst_b <= 1'b1;
        factory_b <= 1'b1;
        while (ready !== 1'b1 && k < 3000) begin
            tick();
            k++;
        end
        check(TAPS'(k >= INIT_CYC - 2), TAPS'(1));
        check(TAPS'(k <= INIT_CYC + 10), TAPS'(1));
        exp_w = exp_s;
        check(TAPS'(stored_position), TAPS'(exp_s));
        check(TAPS'(wiper_position), TAPS'(exp_w));
    endtask

    // stray clock edge after release must not start a new frame
    task automatic drv2(input logic [15:0] v, input int n);
        int k;
        lk2.cs_b = 1'b0;
        #100;
        for (k = 0; k < n; k++) begin
            lk2.din = v[15-k];
            #24 lk2.sclk = 1'b1;
            #24 lk2.sclk = 1'b0;
        end
        #100 lk2.cs_b = 1'b1;
        lk2.din = ~lk2.din;
        #24 lk2.sclk = 1'b1;
        #24 lk2.sclk = 1'b0;
        #400;
    endtask

    initial begin
        int k;
        {rst_b, factory_b, cmd_valid, cmd_short} = 4'h0;
        {cmd_op, cmd_code} = 10'h000;
        {lk2.cs_b, lk2.sclk, lk2.din} = 3'b000;
        void'($urandom(40));
        // a select rise after time zero arms the frame flag of the second end
        #1 lk2.cs_b = 1'b1;
        exp_s = 8'h80;
        power_up();
        send(2'b00, 8'h00, 1'b0);
        send(2'b00, 8'hff, 1'b0);
        send(2'b01, 8'h5a, 1'b0);
        send(2'b11, 8'h11, 1'b1);
        send(2'b00, 8'h01, 1'b0);
        send(2'b10, 8'h22, 1'b1);
        send(2'b11, 8'h33, 1'b0);
        for (k = 0; k < 20; k++) begin
            send(2'($urandom), 8'($urandom), 1'($urandom));
        end
        send(2'b01, 8'ha5, 1'b0);
        send(2'b00, 8'h0f, 1'b0);
        // second power-up: the stored code must survive and be recalled
        @(posedge ref_clk);
        rst_b <= 1'b0;
        power_up();
        drv2(16'h003c, 16);
        check(TAPS'({w2, s2}), TAPS'(16'h3c80));
        drv2(16'h1000, 8);
        drv2(16'h00c0, 12);
        drv2(16'h3000, 4);
        check(TAPS'({w2, s2}), TAPS'(16'h3c80));
        check(TAPS'(n_x2), TAPS'(3));
        drv2(16'h3000, 8);
        check(TAPS'({w2, s2}), TAPS'(16'h8080));
        check(TAPS'(n_d2), TAPS'(2));
        close_out();
    end
endmodule
